// ==== src/hid_pkg.sv ====
// Package for the host interface detect block: interface modes, pin field positions,
// strap masks and the settle time that follows reset.
// Assumes it is compiled before every other file of the block.
package hid_pkg;

   // **********************************************************************
   // Interface modes, one-hot.
   // **********************************************************************
   typedef enum logic [7:0] {
      HID_MODE_NONE = 8'h01,
      HID_MODE_UART = 8'h02,
      HID_MODE_SPI = 8'h04,
      HID_MODE_I2C = 8'h08,
      HID_MODE_PAR_SEP_DED = 8'h10,
      HID_MODE_PAR_SEP_MUX = 8'h20,
      HID_MODE_PAR_COM_DED = 8'h40,
      HID_MODE_PAR_COM_MUX = 8'h80
   } hid_mode_t;

   // **********************************************************************
   // Detector states, one-hot.
   // **********************************************************************
   typedef enum logic [2:0] {
      HID_ST_SETTLE = 3'h1,
      HID_ST_SAMPLE = 3'h2,
      HID_ST_LOCKED = 3'h4
   } hid_state_t;

   // Strap pattern, as read from the pins at the sampling moment.
   typedef struct packed {
      logic ale;
      logic i2c_sel;
      logic address_select_strap;
      logic [5:0] addr;
      logic read_strobe_n;
      logic write_strobe_n;
   } hid_strap_t;

   // Serial pin functions handed to the protocol engines.
   typedef struct packed {
      logic uart_rx;
      logic spi_nss;
      logic spi_mosi;
      logic spi_sck;
      logic i2c_sda_in;
      logic i2c_scl_in;
   } hid_serial_in_t;

   // Outputs that the engines want on the data pins.
   typedef struct packed {
      logic uart_tx;
      logic uart_aux_out;
      logic uart_data_request;
      logic spi_miso;
      logic i2c_sda_out;
   } hid_serial_out_t;

   // **********************************************************************
   // Pin positions and strap values.
   // **********************************************************************
   localparam int HID_PIN_SCL = 7;
   localparam int HID_PIN_MISO = 7;
   localparam int HID_PIN_MOSI = 6;
   localparam int HID_PIN_SCK = 5;
   localparam int HID_I2C_ADR_W = 7;
   localparam logic [5:0] HID_MUX_SEP_ADDR = 6'h07;
   localparam logic [5:0] HID_MUX_COM_ADDR = 6'h06;
   localparam logic [5:0] HID_MUX_MASK = 6'h3e;
   localparam logic [6:0] HID_I2C_ADR_RST = 7'h00;

   // Settle time after reset release before the straps are read.
   localparam int HID_SETTLE_NS = 100;
   localparam int HID_CLK_PERIOD_NS = 10;
   localparam int HID_SETTLE_CYC = (HID_SETTLE_NS + HID_CLK_PERIOD_NS - 1) / HID_CLK_PERIOD_NS;

endpackage : hid_pkg

// ==== src/hid_strap_decode.sv ====
// Combinational decoder from a strap pattern to an interface mode.
// Assumes the pattern is already held stable by the caller.
`timescale 1ns/10ps
module hid_strap_decode
   import hid_pkg::*;
(
   // Pattern in.
   input wire hid_strap_t strap,
   // Decoded mode out.
   output hid_mode_t mode
);

   // **********************************************************************
   // Decode.
   // **********************************************************************

   // Parallel wins when the latch pin is high; serial patterns need idle strobes.
   always_comb begin
      mode = HID_MODE_NONE;
      if (strap.ale) begin
         // Dedicated address bus; the straps cannot tell the strobe styles apart here,
         // so the separate-strobe variant is always reported.
         mode = HID_MODE_PAR_SEP_DED;
      end else if ((strap.addr & HID_MUX_MASK) == (HID_MUX_COM_ADDR & HID_MUX_MASK) &&
                   !strap.i2c_sel) begin
         // Multiplexed: bit 0 high is separate strobes, low is common.
         if (strap.addr == HID_MUX_SEP_ADDR) begin
            mode = HID_MODE_PAR_SEP_MUX;
         end else begin
            mode = HID_MODE_PAR_COM_MUX;
         end
      end else if (strap.read_strobe_n && strap.write_strobe_n) begin
         if (strap.i2c_sel) begin
            mode = HID_MODE_I2C;
         end else if (strap.address_select_strap) begin
            mode = HID_MODE_SPI;
         end else begin
            mode = HID_MODE_UART;
         end
      end
   end

endmodule : hid_strap_decode

// ==== src/hid_top.sv ====
// Host interface detect: samples straps after reset, latches the mode and routes pins.
// Assumes pins are synchronous to CORE_CLK and the host ties straps to fixed levels.
// Behaviour
// - Every reset restarts detection from scratch.
// - Straps sampled after reset select the interface.
// - I2C pin selects I2C; strap picks UART/SPI.
// - Serial pins take SPI, UART or I2C functions.
// - Latch pin and address straps pick parallel variants.
`timescale 1ns/10ps
module hid_top
   import hid_pkg::*;
#(
   parameter int SETTLE_CYC = HID_SETTLE_CYC
) (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Strap and control pins.
   input wire logic ALE_IN,
   input wire logic I2C_SEL_IN,
   input wire logic ADDRESS_SELECT_STRAP,
   input wire logic [5:0] ADDR_IN,
   input wire logic READ_STROBE_N,
   input wire logic WRITE_STROBE_N,
   // Serial data pin, two-way.
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Data pins, two-way.
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic [7:0] DATA_OE,
   // Engine side.
   input wire hid_serial_out_t SER_OUT,
   output hid_serial_in_t SER_IN,
   output logic [6:0] I2C_ADDR,
   output hid_mode_t MODE,
   output logic MODE_VALID
);

   // **********************************************************************
   // Detection sequence.
   // **********************************************************************

   hid_state_t state; // Detector state.
   logic [7:0] settle_cnt; // Cycles already spent in settle, counted up from zero.
   hid_strap_t strap_now; // Live strap pattern.
   hid_mode_t decoded; // Mode decoded from the live pattern.

   assign strap_now = '{ale: ALE_IN, i2c_sel: I2C_SEL_IN,
                        address_select_strap: ADDRESS_SELECT_STRAP, addr: ADDR_IN,
                        read_strobe_n: READ_STROBE_N, write_strobe_n: WRITE_STROBE_N};

   // The decoder looks at live pins; only the sampled result is ever used.
   hid_strap_decode hid_strap_decode_i (
      .strap(strap_now),
      .mode(decoded)
   );

   // Reset drops back to settle, so every reset re-runs detection.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= HID_ST_SETTLE;
         settle_cnt <= 8'h00;
      end else begin
         case (state)
            HID_ST_SETTLE: begin
               // Waiting lets the straps settle after the reset phase.
               if (settle_cnt >= 8'(SETTLE_CYC - 1)) begin
                  state <= HID_ST_SAMPLE;
               end else begin
                  settle_cnt <= settle_cnt + 8'h01;
               end
            end
            HID_ST_SAMPLE: begin
               state <= HID_ST_LOCKED;
            end
            HID_ST_LOCKED: begin
               state <= HID_ST_LOCKED;
            end
            default: begin
               state <= HID_ST_SETTLE;
            end
         endcase
      end
   end

   // The mode is caught once; later strap changes are ignored until reset.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MODE <= HID_MODE_NONE;
         MODE_VALID <= 1'b0;
      end else if (state == HID_ST_SAMPLE) begin
         MODE <= decoded;
         MODE_VALID <= 1'b1;
      end
   end

   // The I2C address is the strap level on data pins 6 down to 0, with address bit 0 taken from pin 6.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         I2C_ADDR <= HID_I2C_ADR_RST;
      end else if (state == HID_ST_SAMPLE) begin
         for (int i = 0; i < HID_I2C_ADR_W; i++) begin
            I2C_ADDR[i] <= DATA_IN[6 - i];
         end
      end
   end

   // **********************************************************************
   // Pin routing.
   // **********************************************************************

   // Inputs are gated to the selected mode so idle engines see quiet lines.
   always_comb begin
      SER_IN = '0;
      SER_IN.spi_nss = 1'b1;
      SER_IN.uart_rx = 1'b1;
      SER_IN.i2c_sda_in = 1'b1;
      SER_IN.i2c_scl_in = 1'b1;
      case (MODE)
         HID_MODE_UART: begin
            SER_IN.uart_rx = SDA_IN;
         end
         HID_MODE_SPI: begin
            SER_IN.spi_nss = SDA_IN;
            SER_IN.spi_mosi = DATA_IN[HID_PIN_MOSI];
            SER_IN.spi_sck = DATA_IN[HID_PIN_SCK];
         end
         HID_MODE_I2C: begin
            SER_IN.i2c_sda_in = SDA_IN;
            SER_IN.i2c_scl_in = DATA_IN[HID_PIN_SCL];
         end
         default: begin
            SER_IN.uart_rx = 1'b1;
         end
      endcase
   end

   // Output drivers come from flip-flops; nothing drives before a mode is locked.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         DATA_OUT <= 8'h00;
         DATA_OE <= 8'h00;
      end else begin
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         DATA_OUT <= 8'h00;
         DATA_OE <= 8'h00;
         case (MODE)
            HID_MODE_UART: begin
               DATA_OUT[7] <= SER_OUT.uart_tx;
               DATA_OUT[6] <= SER_OUT.uart_aux_out;
               DATA_OUT[5] <= SER_OUT.uart_data_request;
               DATA_OE <= 8'he0;
            end
            HID_MODE_SPI: begin
               DATA_OUT[HID_PIN_MISO] <= SER_OUT.spi_miso;
               DATA_OE <= 8'h80;
            end
            HID_MODE_I2C: begin
               // Open drain: drive only the low level.
               SDA_OE <= !SER_OUT.i2c_sda_out;
            end
            default: begin
               SDA_OE <= 1'b0;
            end
         endcase
      end
   end

   // **********************************************************************
   // Checks.
   // **********************************************************************

   a_mode_held: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      MODE_VALID |=> $stable(MODE) && MODE_VALID)
      else $error("Mode changed after lock.");

   a_sample_latch: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      state == HID_ST_SAMPLE |=> MODE == $past(decoded) && MODE_VALID)
      else $error("Sampled mode not latched.");

   a_reset_redetect: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(MODE_VALID) |-> $past(state) == HID_ST_SAMPLE)
      else $error("Mode valid without sampling.");

   a_i2c_pick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      state == HID_ST_SAMPLE && !ALE_IN && I2C_SEL_IN && READ_STROBE_N && WRITE_STROBE_N
      |=> MODE == HID_MODE_I2C)
      else $error("I2C strap not honoured.");

   a_spi_pick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      state == HID_ST_SAMPLE && !ALE_IN && !I2C_SEL_IN && ADDRESS_SELECT_STRAP &&
      ADDR_IN == 6'h00 && READ_STROBE_N && WRITE_STROBE_N |=> MODE == HID_MODE_SPI)
      else $error("SPI strap not honoured.");

   a_ale_pick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      state == HID_ST_SAMPLE && ALE_IN |=> MODE == HID_MODE_PAR_SEP_DED)
      else $error("Dedicated bus strap not honoured.");

   a_mux_pick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      state == HID_ST_SAMPLE && !ALE_IN && !I2C_SEL_IN && ADDR_IN[5:1] == 5'h03
      |=> MODE == ($past(ADDR_IN[0]) ? HID_MODE_PAR_SEP_MUX : HID_MODE_PAR_COM_MUX))
      else $error("Multiplexed bus strap not honoured.");

   a_spi_route: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      MODE == HID_MODE_SPI |-> SER_IN.spi_nss == SDA_IN &&
      SER_IN.spi_sck == DATA_IN[HID_PIN_SCK])
      else $error("SPI pins misrouted.");

   a_uart_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      MODE == HID_MODE_UART && $past(MODE) == HID_MODE_UART |=> DATA_OE == 8'he0)
      else $error("UART outputs not driven.");

   a_no_early_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !MODE_VALID |=> DATA_OE == 8'h00 && !SDA_OE)
      else $error("Pins driven before lock.");

endmodule : hid_top

// ==== tb/hid_host_model.sv ====
// Host side model: ties the strap pins and drives the shared data lines.
// Assumes the bench gives it a strap pattern and the levels that it wants on the lines.
`timescale 1ns/10ps
module hid_host_model
   import hid_pkg::*;
(
   // Wanted levels.
   input wire hid_strap_t cfg,
   input wire logic [7:0] host_data,
   input wire logic host_sda,
   // Device side of the two-way pins.
   input wire logic [7:0] dev_data,
   input wire logic [7:0] dev_oe,
   input wire logic dev_sda,
   input wire logic dev_sda_oe,
   // Resolved pin levels.
   output hid_strap_t strap,
   output logic [7:0] data_wire,
   output logic sda_wire
);
   // Straps are hard wired, so they follow the pattern only.
   assign strap = cfg;
   // A line carries whichever party drives it.
   assign data_wire = (dev_oe & dev_data) | (~dev_oe & host_data);
   // The serial data line carries the device level while the device drives it, else the host level.
   assign sda_wire = dev_sda_oe ? dev_sda : host_sda;
endmodule : hid_host_model

// ==== tb/host_interface_detect_tb.sv ====
// Bench for host interface detection: seven strap patterns, pin routing, later strap changes.
// Assumes the design samples straps a fixed settle time after each reset release.
`timescale 1ns/10ps
module host_interface_detect_tb
   import hid_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   hid_strap_t cfg = 11'h003;
   logic [7:0] host_data = 8'h00;
   logic host_sda = 1'b1;
   hid_serial_out_t ser_out = 5'h00;
   hid_strap_t strap;
   logic [7:0] data_wire, data_out, data_oe;
   logic sda_wire, sda_out, sda_oe, mode_valid, prev_valid;
   hid_serial_in_t ser_in;
   logic [6:0] i2c_addr;
   hid_mode_t mode;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] lfsr = 32'h00012fb0;
   // Expected results: mode, address check flag, address.
   logic [15:0] q[$];
   hid_strap_t tbl[7];
   hid_mode_t md[7];

   hid_host_model hid_host_model_i (.cfg(cfg), .host_data(host_data), .host_sda(host_sda),
      .dev_data(data_out), .dev_oe(data_oe), .dev_sda(sda_out), .dev_sda_oe(sda_oe),
      .strap(strap), .data_wire(data_wire), .sda_wire(sda_wire));

   // A short settle keeps each detection brief.
   hid_top #(.SETTLE_CYC(3)) hid_top_i (.CORE_CLK(core_clk), .RST_N(rst_n),
      .ALE_IN(strap.ale), .I2C_SEL_IN(strap.i2c_sel),
      .ADDRESS_SELECT_STRAP(strap.address_select_strap), .ADDR_IN(strap.addr),
      .READ_STROBE_N(strap.read_strobe_n), .WRITE_STROBE_N(strap.write_strobe_n),
      .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DATA_IN(data_wire),
      .DATA_OUT(data_out), .DATA_OE(data_oe), .SER_OUT(ser_out), .SER_IN(ser_in),
      .I2C_ADDR(i2c_addr), .MODE(mode), .MODE_VALID(mode_valid));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // Automatic, because the monitor and the scenario may compare in the same time step.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One step of the stimulus shift register.
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   task end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // Resets, detects one pattern, checks routing, then disturbs the straps.
   task run(input hid_strap_t s, input hid_mode_t m);
      int k;
      logic [7:0] d;
      logic [6:0] a;
      d = lfsr[7:0];
      for (k = 0; k < 7; k++) begin
         a[k] = d[6 - k];
      end
      @(posedge core_clk);
      rst_n <= 1'b0;
      cfg <= s;
      host_data <= d;
      host_sda <= lfsr[13];
      ser_out <= lfsr[12:8];
      lfsr <= lfsr_next(lfsr);
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      q.push_back({m, (m == HID_MODE_I2C), a});
      k = 0;
      while (mode_valid !== 1'b1 && k < 40) begin
         @(posedge core_clk);
         k++;
      end
      check(16'(mode_valid), 16'h0001);
      repeat (3) @(posedge core_clk);
      case (m)
         HID_MODE_UART: begin
            check(16'(data_oe), 16'h00e0);
            check(16'(data_out[7]), 16'(ser_out.uart_tx));
            check(16'(data_out[6]), 16'(ser_out.uart_aux_out));
            check(16'(data_out[5]), 16'(ser_out.uart_data_request));
            check(16'(ser_in.uart_rx), 16'(sda_wire));
         end
         HID_MODE_SPI: begin
            check(16'(data_oe), 16'h0080);
            check(16'(data_out[7]), 16'(ser_out.spi_miso));
            check(16'(ser_in.spi_mosi), 16'(data_wire[6]));
            check(16'(ser_in.spi_sck), 16'(data_wire[5]));
            check(16'(ser_in.spi_nss), 16'(sda_wire));
         end
         HID_MODE_I2C: begin
            check(16'(ser_in.i2c_scl_in), 16'(data_wire[7]));
            check(16'(ser_in.i2c_sda_in), 16'(sda_wire));
            check(16'(sda_oe), 16'(!ser_out.i2c_sda_out));
            check(16'(sda_out), 16'h0000);
         end
         default: begin
            check(16'(data_oe), 16'h0000);
            check(16'(sda_oe), 16'h0000);
         end
      endcase
      cfg <= ~s;
      repeat (3) @(posedge core_clk);
      check(16'(mode), 16'(m));
   endtask : run

   // Takes the oldest note whenever detection completes.
   always @(posedge core_clk) begin
      logic [15:0] e;
      prev_valid <= mode_valid;
      if (mode_valid === 1'b1 && prev_valid !== 1'b1) begin
         if (q.size() == 0) begin
            check(16'(q.size()), 16'h0001);
         end else begin
            e = q.pop_front();
            check(16'(mode), 16'(e[15:8]));
            if (e[7]) begin
               check(16'(i2c_addr), 16'(e[6:0]));
            end
         end
      end
   end

   initial begin
      #20000;
      n_mismatch++;
      end_sim();
   end

   // Each pass restarts detection under a new pattern.
   initial begin
      tbl = '{11'h003, 11'h103, 11'h20b, 11'h4a8, 11'h01f, 11'h01b, 11'h001};
      md = '{HID_MODE_UART, HID_MODE_SPI, HID_MODE_I2C, HID_MODE_PAR_SEP_DED,
         HID_MODE_PAR_SEP_MUX, HID_MODE_PAR_COM_MUX, HID_MODE_NONE};
      for (int i = 0; i < 7; i++) begin
         run(tbl[i], md[i]);
         $display("test %0d done", i);
      end
      check(16'(q.size()), 16'h0000);
      end_sim();
   end
endmodule : host_interface_detect_tb
